/* File: design/smb_cfg_pkg.sv */
package smb_cfg_pkg;
  localparam logic [3:0] ADDR_HIGH = 4'hb;
  localparam int ADDR_STRAP_W = 3;
  localparam logic [7:0] CMD_CFG = 8'h08;
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 2;
  localparam int OFFSET_W = 8;
  localparam int DATA_W = 16;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic ACK_BIT = 1'b0;
  localparam logic NACK_BIT = 1'b1;
  localparam logic [7:0] RESERVED_READ = 8'hff;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned LINK_HALF_NS = 40;
  localparam int unsigned LINK_HALF_CYC =
    (LINK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_HAVE_PTR,
    SEQ_HAVE_CMD
  } seq_t;
endpackage

/* File: design/smb_link_if.sv */
`timescale 1ns/1ps
interface smb_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
    input scl, input sda);
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface

/* File: design/smb_cfg_slave.sv */
`timescale 1ns/1ps
// What this block does
// - low address bits come from three straps
// - upper address bits fixed, default 1011000b
// - write uses two 08h transfers: pointer, data
// - byte after command is register offset
// - port byte selects ports 0 to 3
// - first data byte low, second high
// - read: pointer write, 08h, restart, read
// - read returns low byte then high
// - address lsb zero write, one read
// - all read/write registers reachable
// - preloadable read-only registers also writable
// - device is slave only
module smb_cfg_slave
  import smb_cfg_pkg::*;
#(
  parameter int NREGS = 256
) (
  input wire logic clk,
  input wire logic arst_n,
  smb_link_if.slave link,
  input wire logic [ADDR_STRAP_W-1:0] addr_strap,
  output logic [OFFSET_W-1:0] cfg_offset,
  output logic [PORT_W-1:0] cfg_port,
  output logic [DATA_W-1:0] cfg_wdata,
  output logic cfg_we
);
  initial begin
    if (NREGS != 256) $error("NREGS must be 256");
  end

  logic [DATA_W-1:0] regs [NUM_PORTS][NREGS];
  logic [1:0] scl_s_q, sda_s_q;
  logic scl_d1_q, sda_d1_q;
  logic [ADDR_STRAP_W-1:0] strap_q, strap_s_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic active_q, rd_q, ack_ph_q, addr_ph_q, tx_q, nack_q;
  logic [1:0] byte_q;
  seq_t seq_q;
  logic [OFFSET_W-1:0] off_q;
  logic [7:0] port_q;
  logic [7:0] lo_q;
  logic sda_o_q, sda_oe_q;
  logic [OFFSET_W-1:0] cfg_offset_q;
  logic [PORT_W-1:0] cfg_port_q;
  logic [DATA_W-1:0] cfg_wdata_q;
  logic cfg_we_q;

  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl & ~scl_d1_q;
  wire scl_fall = ~scl & scl_d1_q;
  wire start_c = scl & scl_d1_q & sda_d1_q & ~sda;
  wire stop_c = scl & scl_d1_q & ~sda_d1_q & sda;
  wire [7:0] rx_byte = {sh_q[6:0], sda};
  wire [6:0] my_addr = {ADDR_HIGH, strap_q};
  // at the ack fall the full address byte already sits in the shifter
  wire addr_hit = sh_q[7:1] == my_addr;
  wire port_ok = port_q < 8'(NUM_PORTS);
  wire [PORT_W-1:0] port_sel = port_q[PORT_W-1:0];
  wire [DATA_W-1:0] rd_word = port_ok ? regs[port_sel][off_q]
                                      : {RESERVED_READ, RESERVED_READ};
  wire [7:0] tx_byte = byte_q == 2'd0 ? rd_word[7:0] : rd_word[15:8];

  assign link.sda_s_o = sda_o_q;
  assign link.sda_s_oe = sda_oe_q;
  assign cfg_offset = cfg_offset_q;
  assign cfg_port = cfg_port_q;
  assign cfg_wdata = cfg_wdata_q;
  assign cfg_we = cfg_we_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      strap_s_q <= '0;
      strap_q <= '0;
    end else begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
      scl_d1_q <= scl;
      sda_d1_q <= sda;
      strap_s_q <= addr_strap;
      strap_q <= strap_s_q;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= 1'b0;
      rd_q <= 1'b0;
      ack_ph_q <= 1'b0;
      addr_ph_q <= 1'b0;
      tx_q <= 1'b0;
      nack_q <= 1'b0;
      bit_q <= '0;
      sh_q <= '0;
      byte_q <= '0;
      seq_q <= SEQ_IDLE;
      off_q <= '0;
      port_q <= '0;
      lo_q <= '0;
      sda_o_q <= 1'b1;
      sda_oe_q <= 1'b0;
      cfg_offset_q <= '0;
      cfg_port_q <= '0;
      cfg_wdata_q <= '0;
      cfg_we_q <= 1'b0;
    end else begin
      cfg_we_q <= 1'b0;
      if (start_c) begin
        active_q <= 1'b1;
        addr_ph_q <= 1'b1;
        ack_ph_q <= 1'b0;
        tx_q <= 1'b0;
        bit_q <= '0;
        byte_q <= '0;
        sda_oe_q <= 1'b0;
      end else if (stop_c) begin
        active_q <= 1'b0;
        sda_oe_q <= 1'b0;
        if (seq_q == SEQ_HAVE_CMD) begin
          seq_q <= SEQ_HAVE_PTR;
        end
      end else if (active_q && scl_rise && !ack_ph_q && !tx_q) begin
        sh_q <= rx_byte;
        bit_q <= bit_q + 4'd1;
      end else if (active_q && scl_rise && ack_ph_q && tx_q) begin
        nack_q <= sda;
      end else if (active_q && scl_fall) begin
        if (ack_ph_q) begin
          ack_ph_q <= 1'b0;
          bit_q <= '0;
          if (tx_q && !nack_q) begin
            sda_oe_q <= ~tx_byte[7];
            sda_o_q <= tx_byte[7];
            sh_q <= {tx_byte[6:0], 1'b1};
            bit_q <= 4'd1;
          end else begin
            sda_oe_q <= 1'b0;
            if (tx_q) begin
              active_q <= 1'b0;
              seq_q <= SEQ_IDLE;
            end
          end
        end else if (tx_q) begin
          if (bit_q == 4'd8) begin
            sda_oe_q <= 1'b0;
            ack_ph_q <= 1'b1;
            byte_q <= byte_q + 2'd1;
          end else begin
            sda_oe_q <= ~sh_q[7];
            sda_o_q <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'b1};
            bit_q <= bit_q + 4'd1;
          end
        end else if (bit_q == 4'd8) begin
          ack_ph_q <= 1'b1;
          if (addr_ph_q) begin
            addr_ph_q <= 1'b0;
            if (addr_hit) begin
              sda_oe_q <= 1'b1;
              sda_o_q <= ACK_BIT;
              rd_q <= sh_q[0];
              tx_q <= sh_q[0] == RW_READ;
              nack_q <= 1'b0;
            end else begin
              active_q <= 1'b0;
            end
          end else begin
            sda_oe_q <= 1'b1;
            sda_o_q <= ACK_BIT;
            byte_q <= byte_q + 2'd1;
            if (byte_q == 2'd0) begin
              if (sh_q == CMD_CFG) begin
                // a pointer already held means this frame carries data
                if (seq_q == SEQ_IDLE) begin
                  seq_q <= SEQ_HAVE_CMD;
                end
              end else begin
                sda_o_q <= NACK_BIT;
              end
            end else if (byte_q == 2'd1) begin
              if (seq_q == SEQ_HAVE_CMD) begin
                off_q <= sh_q;
              end else begin
                lo_q <= sh_q;
              end
            end else if (byte_q == 2'd2) begin
              if (seq_q == SEQ_HAVE_CMD) begin
                port_q <= sh_q;
              end else begin
                seq_q <= SEQ_IDLE;
                if (port_ok) begin
                  cfg_we_q <= 1'b1;
                  cfg_offset_q <= off_q;
                  cfg_port_q <= port_sel;
                  cfg_wdata_q <= {sh_q, lo_q};
                end
              end
            end else begin
              sda_o_q <= NACK_BIT;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (cfg_we_q) begin
      regs[cfg_port_q][cfg_offset_q] <= cfg_wdata_q;
    end
  end
endmodule

/* File: design/smb_cfg_master.sv */
`timescale 1ns/1ps
module smb_cfg_master
  import smb_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  smb_link_if.master link,
  input wire logic req,
  input wire logic req_read,
  input wire logic [6:0] dev_addr,
  input wire logic [OFFSET_W-1:0] req_offset,
  input wire logic [7:0] req_port,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic busy,
  output logic done,
  output logic nacked,
  output logic [DATA_W-1:0] rdata
);
  // byte script: 0 start, 1..8 data/flags, terminated per list
  typedef enum logic [2:0] {
    M_IDLE,
    M_START,
    M_BIT,
    M_STOP,
    M_DONE
  } mst_t;
  mst_t st_q;
  logic [3:0] step_q;
  logic [3:0] bit_q;
  logic [1:0] ph_q;
  logic [7:0] cnt_q;
  logic [8:0] sh_q;
  logic rd_q, nack_q, busy_q, done_q;
  logic [6:0] addr_q;
  logic [OFFSET_W-1:0] off_q;
  logic [7:0] port_q;
  logic [DATA_W-1:0] wd_q, rd_data_q;
  logic scl_q, sda_q;
  logic [1:0] sda_s_q;
  // steps: 0 addr W,1 cmd,2 off,3 port,stop,4 addr W,5 cmd,6 d1/ addr R,7 d2/rd1,8 rd2
  wire [3:0] last_step = rd_q ? 4'd8 : 4'd7;
  // repeated start follows the command byte of the second frame
  wire restart_step = rd_q && step_q == 4'd5;
  wire is_rx = rd_q && step_q >= 4'd7;
  wire tick = cnt_q == 8'(LINK_HALF_CYC - 1);
  logic [7:0] byte_out;
  always_comb begin
    byte_out = 8'hff;
    unique case (step_q)
      4'd0, 4'd4: byte_out = {addr_q, RW_WRITE};
      4'd1, 4'd5: byte_out = CMD_CFG;
      4'd2: byte_out = off_q;
      4'd3: byte_out = port_q;
      4'd6: byte_out = rd_q ? {addr_q, RW_READ} : wd_q[7:0];
      4'd7: byte_out = rd_q ? 8'hff : wd_q[15:8];
      default: byte_out = 8'hff;
    endcase
  end
  assign link.scl_o = 1'b0;
  assign link.scl_oe = ~scl_q;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = ~sda_q;
  assign busy = busy_q;
  assign done = done_q;
  assign nacked = nack_q;
  assign rdata = rd_data_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_s_q <= 2'b11;
    end else begin
      sda_s_q <= {sda_s_q[0], link.sda};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= M_IDLE;
      step_q <= '0;
      bit_q <= '0;
      ph_q <= '0;
      cnt_q <= '0;
      sh_q <= '0;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      addr_q <= '0;
      off_q <= '0;
      port_q <= '0;
      wd_q <= '0;
      rd_data_q <= '0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      cnt_q <= tick ? 8'd0 : cnt_q + 8'd1;
      unique case (st_q)
        M_IDLE: begin
          cnt_q <= '0;
          if (req) begin
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            rd_q <= req_read;
            addr_q <= dev_addr;
            off_q <= req_offset;
            port_q <= req_port;
            wd_q <= req_wdata;
            step_q <= '0;
            ph_q <= '0;
            st_q <= M_START;
          end
        end
        M_START: if (tick) begin
          ph_q <= ph_q + 2'd1;
          if (ph_q == 2'd0) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
          end else if (ph_q == 2'd1) begin
            sda_q <= 1'b0;
          end else begin
            scl_q <= 1'b0;
            ph_q <= '0;
            bit_q <= '0;
            sh_q <= {byte_out, 1'b1};
            st_q <= M_BIT;
          end
        end
        M_BIT: if (tick) begin
          if (!scl_q) begin
            sda_q <= is_rx && bit_q < 4'd8 ? 1'b1
                   : is_rx ? (step_q == last_step) : sh_q[8];
            scl_q <= 1'b1;
          end else begin
            scl_q <= 1'b0;
            sh_q <= {sh_q[7:0], sda_s_q[1]};
            bit_q <= bit_q + 4'd1;
            if (bit_q == 4'd8) begin
              if (!is_rx && sda_s_q[1] == NACK_BIT) begin
                nack_q <= 1'b1;
                st_q <= M_STOP;
              end else begin
                if (is_rx) begin
                  rd_data_q <= step_q == 4'd7 ? {rd_data_q[15:8], sh_q[7:0]}
                                              : {sh_q[7:0], rd_data_q[7:0]};
                end
                bit_q <= '0;
                step_q <= step_q + 4'd1;
                sh_q <= {8'hff, 1'b1};
                if (step_q == 4'd3 || step_q == last_step) begin
                  st_q <= M_STOP;
                end else if (restart_step) begin
                  st_q <= M_START;
                end
              end
            end
          end
          if (!scl_q && bit_q == 4'd0 && step_q != 4'd0) begin
            sh_q <= {byte_out, 1'b1};
            sda_q <= byte_out[7];
          end
        end
        M_STOP: if (tick) begin
          ph_q <= ph_q + 2'd1;
          if (ph_q == 2'd0) begin
            sda_q <= 1'b0;
          end else if (ph_q == 2'd1) begin
            scl_q <= 1'b1;
          end else begin
            sda_q <= 1'b1;
            ph_q <= '0;
            if (!nack_q && step_q == 4'd4) begin
              st_q <= M_START;
            end else begin
              st_q <= M_DONE;
            end
          end
        end
        M_DONE: begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          st_q <= M_IDLE;
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end
endmodule

/* File: tb/smb_link_props.sv */
`timescale 1ns/1ps
module smb_link_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, frm_q, rd_q;
  logic [3:0] bitn_q;
  logic [2:0] byte_q;
  wire rise = scl && !scl_q;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  wire rdb = rd_q && (byte_q == 3'h1 || byte_q == 3'h2);
  wire data_bit = bitn_q inside {[4'h1:4'h8]};
  // frame, bit and byte tracking on the wire
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      frm_q <= 1'b0;
      rd_q <= 1'b0;
      bitn_q <= 4'h0;
      byte_q <= 3'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start || stop) begin
        frm_q <= start;
        rd_q <= 1'b0;
        bitn_q <= 4'h0;
        byte_q <= 3'h0;
      end else if (rise) begin
        bitn_q <= (bitn_q == 4'h9) ? 4'h1 : bitn_q + 4'h1;
        byte_q <= byte_q + {2'h0, bitn_q == 4'h9};
        if (byte_q == 3'h0 && bitn_q == 4'h7) rd_q <= sda;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_hi;
    frm_q && scl && scl_q;
  endsequence
  property p_start_master;
    $fell(sda) && scl && $past(scl) |-> sda_m_oe;
  endproperty
  property p_stop_master;
    $rose(sda) && scl && $past(scl) |-> !sda_s_oe && $past(sda_m_oe);
  endproperty
  property p_slave_edge;
    $changed(sda_s_oe) |-> !scl;
  endproperty
  property p_slave_quiet;
    s_hi ##0 (data_bit && !rdb) |-> !sda_s_oe;
  endproperty
  property p_master_quiet;
    s_hi ##0 (data_bit && rdb) |-> !sda_m_oe;
  endproperty
  property p_wr_ack_free;
    s_hi ##0 (bitn_q == 4'h9 && !rdb) |-> !sda_m_oe;
  endproperty
  property p_rd_ack;
    s_hi ##0 (bitn_q == 4'h9 && rd_q && byte_q == 3'h1) |-> sda_m_oe && !sda_s_oe;
  endproperty
  property p_rd_nack;
    s_hi ##0 (bitn_q == 4'h9 && rd_q && byte_q == 3'h2) |-> !sda_m_oe && !sda_s_oe;
  endproperty
  a_start_master: assert property (p_start_master)
    else $error("start not made by master");
  a_stop_master: assert property (p_stop_master)
    else $error("stop not made by master");
  a_slave_edge: assert property (p_slave_edge)
    else $error("slave changed data line while clock high");
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("slave drove data while master sends");
  a_master_quiet: assert property (p_master_quiet)
    else $error("master drove data while slave sends");
  a_wr_ack_free: assert property (p_wr_ack_free)
    else $error("master held data line in slave ack slot");
  a_rd_ack: assert property (p_rd_ack)
    else $error("first read byte not acked by master");
  a_rd_nack: assert property (p_rd_nack)
    else $error("last read byte not left unacked");
endmodule

/* File: tb/tb_smb_cfg_slave.sv */
`timescale 1ns/1ps
module tb_smb_cfg_slave
  import smb_cfg_pkg::*;
;
  logic clk, arst_n, req, req_read, busy, done, nacked, cfg_we;
  logic [6:0] dev_addr;
  logic [7:0] req_offset, req_port, cfg_offset;
  logic [15:0] req_wdata, rdata, cfg_wdata;
  logic [2:0] addr_strap;
  logic [1:0] cfg_port;
  int mismatches = 0;
  int total_checks = 0;
  int wr_cnt = 0;
  int cyc = 0;
  smb_link_if link ();
  smb_cfg_master i_smb_cfg_master (.clk(clk), .arst_n(arst_n), .link(link.master),
    .req(req), .req_read(req_read), .dev_addr(dev_addr), .req_offset(req_offset),
    .req_port(req_port), .req_wdata(req_wdata), .busy(busy), .done(done),
    .nacked(nacked), .rdata(rdata));
  smb_cfg_slave i_smb_cfg_slave (.clk(clk), .arst_n(arst_n), .link(link.slave),
    .addr_strap(addr_strap), .cfg_offset(cfg_offset), .cfg_port(cfg_port),
    .cfg_wdata(cfg_wdata), .cfg_we(cfg_we));
  smb_link_props i_smb_link_props (.clk(clk), .arst_n(arst_n), .scl_o(link.scl_o),
    .scl_oe(link.scl_oe), .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe),
    .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cfg_we === 1'b1) wr_cnt <= wr_cnt + 1;
    if (cyc == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one complete access by the master end, waiting for its done pulse
  task xfer(input logic rd, input logic [6:0] a, input logic [7:0] o, input logic [7:0] p,
    input logic [15:0] w);
    repeat (2) @(posedge clk);
    req <= 1'b1;
    req_read <= rd;
    dev_addr <= a;
    req_offset <= o;
    req_port <= p;
    req_wdata <= w;
    @(posedge clk);
    req <= 1'b0;
    for (int n = 0; n < 4000 && done !== 1'b1; n++) @(posedge clk);
  endtask
  task wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] p,
    input logic [15:0] w, input logic nk);
    int c0;
    c0 = wr_cnt;
    xfer(RW_WRITE, a, o, p, w);
    chk("write nack", {15'h0, nk}, {15'h0, nacked});
    chk("write count", (nk || p > 8'h3) ? 16'h0 : 16'h1, 16'(wr_cnt - c0));
    if (!nk && p < 8'h4) begin
      chk("offset", {8'h0, o}, {8'h0, cfg_offset});
      chk("port", {8'h0, p}, {14'h0, cfg_port});
      chk("wdata", w, cfg_wdata);
    end
  endtask
  task rd(input logic [6:0] a, input logic [7:0] o, input logic [7:0] p,
    input logic [15:0] exp);
    xfer(RW_READ, a, o, p, 16'h0);
    chk("read nack", 16'h0, {15'h0, nacked});
    chk("read data", exp, rdata);
    chk("busy", 16'h0, {15'h0, busy});
  endtask
  initial begin
    arst_n = 1'b0;
    req = 1'b0;
    req_read = 1'b0;
    dev_addr = 7'h0;
    req_offset = 8'h0;
    req_port = 8'h0;
    req_wdata = 16'h0;
    addr_strap = 3'h0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    wr(7'h58, 8'hb4, 8'h01, 16'h1234, 1'b0);
    rd(7'h58, 8'hb4, 8'h01, 16'h1234);
    for (int i = 0; i < 4; i++) wr(7'h58, 8'hff, 8'(i), 16'ha5c0 + 16'(i), 1'b0);
    wr(7'h58, 8'h00, 8'h02, 16'h00ff, 1'b0);
    wr(7'h58, 8'hff, 8'h04, 16'hdead, 1'b0);
    for (int i = 0; i < 4; i++) rd(7'h58, 8'hff, 8'(i), 16'ha5c0 + 16'(i));
    rd(7'h58, 8'h00, 8'h02, 16'h00ff);
    rd(7'h58, 8'hff, 8'h04, {RESERVED_READ, RESERVED_READ});
    addr_strap <= 3'h5;
    repeat (4) @(posedge clk);
    wr(7'h58, 8'h10, 8'h03, 16'hbeef, 1'b1);
    wr(7'h1d, 8'h10, 8'h03, 16'hbeef, 1'b1);
    wr(7'h5d, 8'h10, 8'h03, 16'hbeef, 1'b0);
    rd(7'h5d, 8'h10, 8'h03, 16'hbeef);
    stop_test();
  end
endmodule
